// file: design/ssi_pkg.sv
/*
  Package for the synchronous serial interface: register offsets, fields,
  reset values, modes and timing counts.
  Assumes a 20 MHz system clock and a plain strobe register port.
*/
package ssi_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_TX_BUFFER = 3'h3;
  localparam logic [2:0] ADDR_RX_BUFFER = 3'h4;
  // ----------------------------------------------------------------
  // Control register 1 fields
  // ----------------------------------------------------------------
  localparam int CTRL1_RESET_BIT = 3;
  localparam int CTRL1_CLKDIR_BIT = 2;
  localparam int CTRL1_SRC1_BIT = 1;
  localparam int CTRL1_SRC0_BIT = 0;
  localparam logic [3:0] CTRL1_RESET_VAL = 4'hF;
  // ----------------------------------------------------------------
  // Control register 2 fields
  // ----------------------------------------------------------------
  localparam int CTRL2_DIR_BIT = 3;
  localparam int CTRL2_MODE_HI = 2;
  localparam int CTRL2_MODE_LO = 1;
  localparam int CTRL2_IE_BIT = 0;
  localparam logic [3:0] CTRL2_RESET_VAL = 4'h0;
  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_ACT_BIT = 1;
  localparam int STAT_TACK_BIT = 2;
  localparam int STAT_RACK_BIT = 3;
  localparam logic [7:0] BUF_RESET_VAL = 8'h00;
  // ----------------------------------------------------------------
  // Transfer modes (edge_mode_bit1, edge_mode_bit0)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSI_MODE_SYNC_RISE = 2'b00,
    SSI_MODE_SYNC_FALL = 2'b01,
    SSI_MODE_LINK9 = 2'b10,
    SSI_MODE_LINK8 = 2'b11
  } ssi_mode_t;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int WORD_BITS = 8;
  localparam int LINK_HALF_NS = 2500;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * (CLK_HZ / 1000000) + 999)
    / 1000;
endpackage

// file: design/ssi_core.sv
/*
  Synchronous serial interface: 8-bit shift register with transmit and
  receive buffers, synchronous NRZ mode and two link master modes.
  Assumes pins are resolved outside from output/enable pairs, and a single
  system clock; the shift clock pin in input mode is sampled and edged.
*/
// The plain strobed port and the address map are this design's own decisions.
// Summary of operation
// RULE1 - One 8-bit shift register plus software-accessible rx and tx buffers.
// RULE2 - Shift clock comes from internal source or external pin, per bit.
// RULE3 - Modes: sync 8-bit, 9-bit link with ack, 8-bit link no ack.
// RULE4 - Link modes frame every dialog with start and stop conditions.
// RULE5 - Link modes always generate the shift clock; device is master.
// RULE6 - Data pin direction follows the data direction bit automatically.
// RULE7 - Words are eight bits, shifted most significant bit first.
// RULE8 - The 9-bit link mode appends one acknowledge bit per word.
// RULE9 - Word start loads tx buffer to shifter; completed word goes to rx.
// RULE10 - Interface idles while reset bit is 1; clearing it activates.
// RULE11 - Ready flag tracks relevant buffer; shifting pauses until serviced.
// RULE12 - Activity flag high during word and start/stop; both readable.
// RULE13 - Sync mode is NRZ, 2 or 3 wire; mode bits choose output edge.
// RULE14 - Sync input sampled on the edge opposite the output change edge.
// RULE15 - Software picks sync mode 1 when used with a timer modulator.
// RULE16 - In receive, activation produces eight shift clocks shifting data in.
// RULE17 - First received word clears ready and requests interrupt if enabled.
// RULE18 - Receive stalls holding the next word while buffer is unread.
// RULE19 - Deactivating mid-word stops clock and latches partial word to rx.
// RULE20 - Software reads last word before deactivation; latch overwrites it.
// RULE21 - Two-wire: one bidirectional data pin and one shift clock pin.
// RULE22 - Three-wire: separate input pin, clock pin, output via timer stage.
// RULE23 - Transmit starts shifting only after the tx buffer is loaded.
// RULE24 - Clock direction 1 drives clock pin; 0 makes it input, ignore sources.
// RULE25 - In link modes clearing reset bit starts, setting it stops.
// RULE26 - After reset: inactive, clock idle, buffers clear, activity low.
// RULE27 - Buffer interrupt is one pulse per completed word when enabled.
`timescale 1ns/1ps
module ssi_core #(
  parameter int HALF_CYC = ssi_pkg::LINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] int_clk_src,
  input wire logic shift_clock_line_in,
  output logic shift_clock_line_out,
  output logic shift_clock_line_oe,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  output logic serial_out_internal,
  output logic buffer_irq
);
  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSI_IDLE = 3'b000,
    SSI_START = 3'b001,
    SSI_WAIT = 3'b010,
    SSI_SHIFT = 3'b011,
    SSI_ACK = 3'b100,
    SSI_STOP = 3'b101
  } ssi_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic iface_reset_ctrl;
  logic clock_direction_bit;
  logic clk_source_sel1;
  logic clk_source_sel0;
  logic data_direction_bit;
  logic edge_mode_bit1;
  logic edge_mode_bit0;
  logic irq_enable;
  logic rx_ack_value;
  logic tx_ack_value;
  logic [7:0] tx_buffer;
  logic [7:0] rx_buffer;
  logic tx_full;
  logic rx_full;
  logic rx_hold;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic [15:0] half_cnt;
  logic sc_gen;
  logic sd_drive;
  logic sd_oe_link;
  logic [2:0] sc_sync;
  logic [2:0] sd_sync;
  logic [2:0] src_sync;
  logic sc_filt;
  logic src_filt;
  logic sc_filt_d;
  logic src_filt_d;
  ssi_state_t state;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Mode selection from the two mode bits
  wire ssi_pkg::ssi_mode_t mode = ssi_pkg::ssi_mode_t'({edge_mode_bit1,
    edge_mode_bit0});
  wire is_link = edge_mode_bit1; // RULE3
  wire has_ack = (mode == ssi_pkg::SSI_MODE_LINK9); // RULE8
  wire clk_out_mode = clock_direction_bit | is_link; // RULE5
  wire tx_mode = data_direction_bit;
  wire active = ~iface_reset_ctrl; // RULE10
  // Ready flag: tx buffer loaded in tx mode, rx buffer free in rx mode
  wire buffer_ready_flag = tx_mode ? tx_full : ~rx_full; // RULE11
  wire activity_flag = (state != SSI_IDLE) && (state != SSI_WAIT); // RULE12
  wire wr_ctrl1 = reg_wr && (reg_addr == ssi_pkg::ADDR_CTRL1);
  wire wr_ctrl2 = reg_wr && (reg_addr == ssi_pkg::ADDR_CTRL2);
  wire wr_status = reg_wr && (reg_addr == ssi_pkg::ADDR_STATUS);
  wire wr_tx = reg_wr && (reg_addr == ssi_pkg::ADDR_TX_BUFFER);
  wire rd_rx = reg_rd && (reg_addr == ssi_pkg::ADDR_RX_BUFFER);
  // Internal clock source select, ignored when clock is external
  wire src_sel = int_clk_src[{clk_source_sel1, clk_source_sel0}]; // RULE24
  // Internal source divided by two: one shift edge per rising source edge
  wire src_edge = src_filt & ~src_filt_d;
  wire half_tick = (half_cnt == 16'(HALF_CYC - 1));
  wire ext_rise = sc_filt & ~sc_filt_d;
  wire ext_fall = ~sc_filt & sc_filt_d;
  // Shift clock edges in the internal sense
  wire int_tick = is_link ? half_tick : src_edge; // RULE2
  wire gen_rise = int_tick & ~sc_gen;
  wire gen_fall = int_tick & sc_gen;
  wire sc_rise = clk_out_mode ? gen_rise : ext_rise; // RULE2
  wire sc_fall = clk_out_mode ? gen_fall : ext_fall;
  // Output changes on falling edge in link or fall mode, else rising
  wire out_edge_fall = is_link | (mode == ssi_pkg::SSI_MODE_SYNC_FALL);
  wire out_edge = out_edge_fall ? sc_fall : sc_rise; // RULE13
  wire in_edge = out_edge_fall ? sc_rise : sc_fall; // RULE14
  wire sd_in = sd_sync[2];
  wire word_done = (state == SSI_SHIFT) && in_edge &&
    (bit_cnt == 4'(ssi_pkg::WORD_BITS - 1));
  wire [7:0] shifted = {shifter[6:0], sd_in}; // RULE7
  wire can_go = active && (tx_mode ? tx_full : !rx_hold); // RULE23
  wire [7:0] status_val = {4'h0, rx_ack_value, tx_ack_value,
    activity_flag, buffer_ready_flag};
  wire [7:0] ctrl1_val = {4'h0, iface_reset_ctrl, clock_direction_bit,
    clk_source_sel1, clk_source_sel0};
  wire [7:0] ctrl2_val = {4'h0, data_direction_bit, edge_mode_bit1,
    edge_mode_bit0, irq_enable};
  // Read data select
  wire [7:0] rd_sel = (reg_addr == ssi_pkg::ADDR_CTRL1) ? ctrl1_val :
    (reg_addr == ssi_pkg::ADDR_CTRL2) ? ctrl2_val :
    (reg_addr == ssi_pkg::ADDR_STATUS) ? status_val :
    (reg_addr == ssi_pkg::ADDR_TX_BUFFER) ? tx_buffer :
    (reg_addr == ssi_pkg::ADDR_RX_BUFFER) ? rx_buffer : 8'h00;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a clock or source change counts when the last two agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sc_sync <= 3'h7;
      sd_sync <= 3'h7;
      src_sync <= 3'h0;
      sc_filt <= 1'b1;
      src_filt <= 1'b0;
    end else begin
      sc_sync <= {sc_sync[1:0], shift_clock_line_in};
      sd_sync <= {sd_sync[1:0], serial_data_line_in};
      src_sync <= {src_sync[1:0], src_sel};
      if (sc_sync[2] == sc_sync[1]) begin
        sc_filt <= sc_sync[2];
      end
      if (src_sync[2] == src_sync[1]) begin
        src_filt <= src_sync[2];
      end
    end
  end

  // Edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sc_filt_d <= 1'b1;
      src_filt_d <= 1'b0;
    end else begin
      sc_filt_d <= sc_filt;
      src_filt_d <= src_filt;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Control bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {iface_reset_ctrl, clock_direction_bit, clk_source_sel1,
        clk_source_sel0} <= ssi_pkg::CTRL1_RESET_VAL; // RULE26
      {data_direction_bit, edge_mode_bit1, edge_mode_bit0,
        irq_enable} <= ssi_pkg::CTRL2_RESET_VAL;
      rx_ack_value <= 1'b0;
    end else begin
      if (wr_ctrl1) begin
        {iface_reset_ctrl, clock_direction_bit, clk_source_sel1,
          clk_source_sel0} <= reg_wdata[3:0]; // RULE10
      end
      if (wr_ctrl2) begin
        {data_direction_bit, edge_mode_bit1, edge_mode_bit0,
          irq_enable} <= reg_wdata[3:0];
      end
      if (wr_status) begin
        rx_ack_value <= reg_wdata[ssi_pkg::STAT_RACK_BIT];
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_sel : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  // Software write sets full; load into shifter empties it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buffer <= ssi_pkg::BUF_RESET_VAL;
      tx_full <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_buffer <= reg_wdata; // RULE1
        tx_full <= 1'b1;
      end else if (state == SSI_WAIT && can_go && tx_mode) begin
        tx_full <= 1'b0; // RULE9
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // Completed or partial word lands here; a read frees it
  wire rx_load_word = word_done && !tx_mode && !rx_full;
  wire rx_load_held = rx_hold && !rx_full;
  wire rx_load_abort = wr_ctrl1 && reg_wdata[ssi_pkg::CTRL1_RESET_BIT] &&
    !is_link && (state == SSI_SHIFT); // RULE19
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buffer <= ssi_pkg::BUF_RESET_VAL; // RULE26
      rx_full <= 1'b0;
      rx_hold <= 1'b0;
      buffer_irq <= 1'b0;
    end else begin
      buffer_irq <= irq_enable && (tx_mode ? word_done :
        (rx_load_word || rx_load_held)); // RULE27
      rx_hold <= rx_full && (rx_hold || (word_done && !tx_mode)); // RULE18
      if (rx_load_word) begin
        rx_buffer <= shifted; // RULE17
      end else if (rx_load_held) begin
        rx_buffer <= shifter; // RULE18
      end else if (rx_load_abort) begin
        rx_buffer <= shifter; // RULE20
      end
      if (rx_load_word || rx_load_held) begin
        rx_full <= 1'b1; // RULE17
      end else if (rd_rx) begin
        rx_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift clock generator
  // ----------------------------------------------------------------
  // Runs only while a word or a link condition is in progress
  wire gen_run = (state == SSI_SHIFT) || (state == SSI_ACK) ||
    (state == SSI_START) || (state == SSI_STOP);
  wire hold_sc = (state == SSI_START) ||
    ((state == SSI_STOP) && (bit_cnt == 4'h1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_cnt <= 16'h0000;
      sc_gen <= 1'b1;
    end else if (!gen_run) begin
      half_cnt <= 16'h0000;
      sc_gen <= 1'b1; // Clock idles high
    end else begin
      half_cnt <= half_tick ? 16'h0000 : half_cnt + 16'h0001;
      if (int_tick && clk_out_mode && !hold_sc) begin
        sc_gen <= ~sc_gen;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // Start, wait for buffer, shift eight bits, ack, stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SSI_IDLE;
      shifter <= ssi_pkg::BUF_RESET_VAL;
      bit_cnt <= 4'h0;
      sd_drive <= 1'b1;
      sd_oe_link <= 1'b0;
      tx_ack_value <= 1'b0;
    end else begin
      case (state)
        SSI_IDLE: begin
          sd_drive <= 1'b1;
          sd_oe_link <= 1'b0;
          if (active) begin
            state <= is_link ? SSI_START : SSI_WAIT; // RULE25
          end
        end
        SSI_START: begin
          sd_oe_link <= 1'b1;
          if (half_tick && sc_gen) begin
            sd_drive <= 1'b0; // RULE4
            state <= SSI_WAIT;
          end
        end
        SSI_WAIT: begin
          bit_cnt <= 4'h0;
          if (!active) begin
            state <= is_link ? SSI_STOP : SSI_IDLE; // RULE25
          end else if (can_go) begin // RULE11
            shifter <= tx_mode ? tx_buffer : shifter; // RULE9
            sd_drive <= (tx_mode && !is_link) ? tx_buffer[7] :
              sd_drive; // RULE13
            state <= SSI_SHIFT; // RULE16
          end
        end
        SSI_SHIFT: begin
          if (out_edge) begin
            sd_oe_link <= is_link & tx_mode; // RULE6
          end
          if (!active && !is_link) begin
            state <= SSI_IDLE; // RULE19
          end else begin
            if (out_edge && tx_mode) begin
              sd_drive <= shifter[7]; // RULE7
            end
            if (in_edge) begin
              shifter <= shifted;
              bit_cnt <= bit_cnt + 4'h1;
              if (word_done) begin
                state <= has_ack ? SSI_ACK : SSI_WAIT;
              end
            end
          end
        end
        SSI_ACK: begin
          if (sc_fall) begin
            sd_oe_link <= ~tx_mode; // RULE8
            sd_drive <= rx_ack_value;
          end
          if (sc_rise) begin
            tx_ack_value <= sd_in;
            state <= SSI_WAIT;
          end
        end
        SSI_STOP: begin
          sd_oe_link <= 1'b1;
          if (sc_fall) begin
            sd_drive <= 1'b0;
          end
          if (sc_rise) begin
            bit_cnt <= 4'h1;
          end
          if (half_tick && hold_sc) begin
            sd_drive <= 1'b1; // RULE4
            state <= SSI_IDLE;
          end
        end
        default: begin
          state <= SSI_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Clock pin driven only when internally generated
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_clock_line_out <= 1'b1;
      shift_clock_line_oe <= 1'b0;
      serial_data_line_out <= 1'b1;
      serial_data_line_oe <= 1'b0;
      serial_out_internal <= 1'b1;
    end else begin
      shift_clock_line_out <= sc_gen;
      shift_clock_line_oe <= clk_out_mode; // RULE24
      serial_data_line_out <= sd_drive; // RULE21
      serial_data_line_oe <= is_link ? sd_oe_link : tx_mode; // RULE6
      serial_out_internal <= sd_drive; // RULE22
    end
  end
endmodule

// file: sim/ssi_core_monitor.sv
/*
  Checker for ssi_core: register answers, pin enables, buffer interrupt.
  Assumes it is bound to ssi_core and sees only that module's ports.
*/
`timescale 1ns/1ps
module ssi_core_monitor #(
  parameter int HALF_CYC = ssi_pkg::LINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] int_clk_src,
  input wire logic shift_clock_line_in,
  input wire logic shift_clock_line_out,
  input wire logic shift_clock_line_oe,
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic serial_out_internal,
  input wire logic buffer_irq
);
  logic [3:0] ctrl1;
  logic [3:0] ctrl2;
  logic [7:0] tx_copy;
  // Shadow of what software wrote
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl1 <= ssi_pkg::CTRL1_RESET_VAL;
      ctrl2 <= ssi_pkg::CTRL2_RESET_VAL;
      tx_copy <= ssi_pkg::BUF_RESET_VAL;
    end else if (reg_wr) begin
      case (reg_addr)
        ssi_pkg::ADDR_CTRL1: ctrl1 <= reg_wdata[3:0];
        ssi_pkg::ADDR_CTRL2: ctrl2 <= reg_wdata[3:0];
        ssi_pkg::ADDR_TX_BUFFER: tx_copy <= reg_wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  a_unmapped_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) > ssi_pkg::ADDR_RX_BUFFER |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl1_back: assert property ($past(reg_rd) &&
    $past(reg_addr) == ssi_pkg::ADDR_CTRL1 |-> reg_rdata[3:0] == $past(ctrl1))
    else $error("control 1 reads back wrong");
  a_tx_back: assert property ($past(reg_rd) &&
    $past(reg_addr) == ssi_pkg::ADDR_TX_BUFFER |-> reg_rdata == $past(tx_copy))
    else $error("transmit buffer reads back wrong");
  a_irq_single: assert property (buffer_irq |=> !buffer_irq)
    else $error("interrupt longer than one cycle");
  a_irq_enabled: assert property (buffer_irq |-> $past(ctrl2[0]))
    else $error("interrupt while disabled");
  a_clk_oe_dir: assert property (ctrl1[2] [*3] |-> shift_clock_line_oe)
    else $error("clock pin not driven as output");
  a_data_oe_tx: assert property ((!ctrl1[3] && ctrl2[3] && !ctrl2[2]) [*3]
    |-> serial_data_line_oe)
    else $error("data pin not driven in transmit");
  a_data_oe_rx: assert property ((!ctrl2[3] && !ctrl2[2]) [*3]
    |-> !serial_data_line_oe)
    else $error("data pin driven in receive");
  a_clk_still: assert property ((ctrl1[3] && !ctrl2[2]) [*6]
    |-> $stable(shift_clock_line_out))
    else $error("shift clock moves while inactive");
endmodule
bind ssi_core ssi_core_monitor #(.HALF_CYC(HALF_CYC)) mon_u (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .int_clk_src(int_clk_src), .shift_clock_line_in(shift_clock_line_in),
  .shift_clock_line_out(shift_clock_line_out),
  .shift_clock_line_oe(shift_clock_line_oe),
  .serial_data_line_in(serial_data_line_in),
  .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe(serial_data_line_oe),
  .serial_out_internal(serial_out_internal), .buffer_irq(buffer_irq));

// file: sim/ssi_partner.sv
/*
  Serial partner on the pins: sends and takes bytes MSB first, answers
  the link acknowledge, notes link start and stop conditions.
  Assumes resolved pins; the data pin has a pull-up.
*/
`timescale 1ns/1ps
module ssi_partner (
  input wire logic sclk,
  input wire logic sd,
  input wire logic arm,
  input wire logic drive,
  input wire logic fall_out,
  input wire logic nine,
  input wire logic [7:0] word_in,
  output logic sd_drv,
  output logic [7:0] got_word,
  output int n_words,
  output int n_samples,
  output logic saw_start,
  output logic saw_stop
);
  logic [7:0] cur;
  logic [7:0] shreg;
  logic bit_out = 1'b1;
  logic ack_on = 1'b0;
  int cnt = 0;
  // Released data pin goes to its pull-up level
  assign sd_drv = (arm && (drive || ack_on)) ? bit_out : 1'b1;
  // Every arming starts a fresh frame
  always @(posedge arm) begin
    cnt = 0;
    n_words = 0;
    n_samples = 0;
    saw_start = 1'b0;
    saw_stop = 1'b0;
    cur = word_in;
    bit_out = word_in[7];
  end
  // Sample on one shift clock edge, change data on the other
  always @(sclk) begin
    if (arm && sclk == fall_out) begin
      shreg = {shreg[6:0], sd};
      n_samples++;
      cnt++;
      if (cnt == 8)
        got_word = shreg;
      if (cnt == (nine ? 9 : 8)) begin
        cnt = 0;
        n_words++;
        cur = word_in;
      end
    end else if (arm) begin
      ack_on = nine && cnt == 8;
      bit_out = ack_on ? 1'b0 : cur[7 - cnt];
    end
  end
  // Data edges while the clock is high frame a link dialog
  always @(negedge sd) begin
    #1;
    if (arm && sclk)
      saw_start = 1'b1;
  end
  always @(posedge sd) begin
    #1;
    if (arm && sclk)
      saw_stop = 1'b1;
  end
endmodule

// file: sim/tb_top.sv
/*
  Self-checking bench for ssi_core: register tasks, serial partner.
  Assumes ssi_partner and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic src_clk = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, p_got, rv, a, b;
  logic sc_out, sc_oe, sd_out, sd_oe, p_drv, irq, p_start, p_stop;
  logic arm = 1'b0;
  logic drive = 1'b0;
  logic fall_out = 1'b0;
  logic nine = 1'b0;
  logic [7:0] word_in = 8'h00;
  logic [1:0] mode;
  int p_words, p_samples, len, s;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int irqs = 0;
  int seed = 10;
  wire logic sc_pin = sc_oe ? sc_out : 1'b1;
  wire logic sd_pin = (sd_oe ? sd_out : 1'b1) & p_drv;
  // System clock and a free-running source of unrelated phase
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #200 src_clk = ~src_clk;
  end
  ssi_core #(.HALF_CYC(8)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .int_clk_src({4{src_clk}}), .shift_clock_line_in(sc_pin),
    .shift_clock_line_out(sc_out), .shift_clock_line_oe(sc_oe),
    .serial_data_line_in(sd_pin), .serial_data_line_out(sd_out),
    .serial_data_line_oe(sd_oe), .serial_out_internal(),
    .buffer_irq(irq));
  ssi_partner peer_u (
    .sclk(sc_pin), .sd(sd_pin), .arm(arm), .drive(drive),
    .fall_out(fall_out), .nine(nine), .word_in(word_in), .sd_drv(p_drv),
    .got_word(p_got), .n_words(p_words), .n_samples(p_samples),
    .saw_start(p_start), .saw_stop(p_stop));
  // Interrupt pulse count and run limit
  always @(posedge clk) begin
    cycles++;
    if (irq === 1'b1)
      irqs++;
    if (cycles == 30000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [2:0] ad, input logic [7:0] m,
                        input logic [7:0] exp, input string what);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rv = reg_rdata;
    check(what, rv & m, exp);
  endtask
  // Waits for samples (0), words (1) or interrupts (2), bounded
  task automatic wait_for(input int which, input int n);
    int k;
    k = 0;
    while ((which == 0 ? p_samples : which == 1 ? p_words : irqs) < n
           && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) begin
      n_errors++;
      $display("Error wait %0d expected %0d seen timeout", which, n);
    end
  endtask
  task automatic finish_test;
    $display("Compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(ssi_pkg::ADDR_CTRL1, 8'h0F, 8'h0F, "ctrl1");
    rd_chk(ssi_pkg::ADDR_CTRL2, 8'h0F, 8'h00, "ctrl2");
    rd_chk(ssi_pkg::ADDR_STATUS, 8'h02, 8'h00, "act");
    rd_chk(ssi_pkg::ADDR_RX_BUFFER, 8'hFF, 8'h00, "rx");
    rd_chk(3'h7, 8'hFF, 8'h00, "unmapped");
    // Transmit two words in every mode, pausing until the second buffer load
    for (int i = 0; i < 4; i++) begin
      mode = i[1:0];
      len = (i == 2) ? 9 : 8;
      s = $random(seed);
      a = s[7:0];
      b = s[15:8];
      fall_out <= (i != 0);
      nine <= (i == 2);
      wr(ssi_pkg::ADDR_CTRL2, {4'h0, 1'b1, mode, 1'b1});
      wr(ssi_pkg::ADDR_TX_BUFFER, a);
      rd_chk(ssi_pkg::ADDR_STATUS, 8'h01, 8'h01, "tx ready");
      arm <= 1'b1;
      wr(ssi_pkg::ADDR_CTRL1, 8'h07);
      wait_for(1, 1);
      check("tx word", p_got, a);
      rd_chk(ssi_pkg::ADDR_STATUS, 8'h01, 8'h00, "tx empty");
      repeat (100) @(posedge clk);
      check("paused", 8'(p_samples), 8'(len));
      wr(ssi_pkg::ADDR_TX_BUFFER, b);
      wait_for(0, len + 3);
      rd_chk(ssi_pkg::ADDR_STATUS, 8'h02, 8'h02, "act");
      wait_for(1, 2);
      check("tx word", p_got, b);
      if (i == 2) rd_chk(ssi_pkg::ADDR_STATUS, 8'h04, 8'h00, "ack");
      wr(ssi_pkg::ADDR_CTRL1, 8'h0F);
      repeat (40) @(posedge clk);
      if (i >= 2) begin
        check("start", {7'h0, p_start}, 8'h01);
        check("stop", {7'h0, p_stop}, 8'h01);
      end
      arm <= 1'b0;
    end
    // Receive: stall on a full buffer, then cut a word short
    s = $random(seed);
    fall_out <= 1'b0;
    nine <= 1'b0;
    drive <= 1'b1;
    word_in <= s[7:0];
    wr(ssi_pkg::ADDR_CTRL2, 8'h01);
    len = irqs;
    arm <= 1'b1;
    wr(ssi_pkg::ADDR_CTRL1, 8'h07);
    word_in <= s[15:8];
    wait_for(2, len + 1);
    rd_chk(ssi_pkg::ADDR_STATUS, 8'h01, 8'h00, "rx full");
    word_in <= s[23:16];
    repeat (400) @(posedge clk);
    check("stall", 8'(p_samples), 8'd16);
    check("one irq", 8'(irqs - len), 8'd1);
    rd_chk(ssi_pkg::ADDR_RX_BUFFER, 8'hFF, s[7:0], "rx word");
    wait_for(2, len + 2);
    rd_chk(ssi_pkg::ADDR_RX_BUFFER, 8'hFF, s[15:8], "rx word");
    wait_for(0, 19);
    repeat (3) @(posedge clk);
    wr(ssi_pkg::ADDR_CTRL1, 8'h0F);
    b = {5'h0, s[23:21]};
    rd_chk(ssi_pkg::ADDR_RX_BUFFER, 8'h07, b, "partial");
    arm <= 1'b0;
    finish_test();
  end
endmodule
